// ### rtl/arc_readout.sv
// result readout, read pointer and standby control of a four-channel converter
// assumes host pins are synchronous to clk_i; the analog core returns a result
// on core_result_i for the channel named by core_ch_o
//
// Behaviour
// - standby input low gives low-current state
// - results stay readable while in standby
// - short standby wakes in two microseconds
// - power-up with internal reference takes 6 ms
// - four twelve-bit result registers
// - results packed in conversion order
// - pointer reset at cycle 12 of first conversion
// - first-result flag high at register one
// - bus driven only while select and read low
// - read edge advances pointer after sequence
// - no advance onto not-yet-valid register
// - conversion end advances pointer during sequence
// - read of last result wraps pointer
// - each conversion takes fourteen clock cycles
// - strobe low at cycle 13, high 14
// - flag clears at second conversion transfer
`timescale 1ns/1ns
`include "arc_cfg.svh"

module arc_readout #(
  parameter int P_LONG_LOW_POWER_REQUEST_N_CYC = `ARC_LONG_LOW_POWER_REQUEST_N_CYC,
  parameter int P_POWERUP_CYC   = `ARC_POWERUP_CYC
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // conversion control
  input  wire logic              sample_trigger_n_i,
  input  wire logic [3:0]        chan_sel_i,
  input  wire logic              low_power_request_n_i,
  // analog core
  input  arc_pkg::arc_word_t     core_result_i,
  output logic [1:0]             core_ch_o,
  // host read port
  input  arc_pkg::arc_host_rd_t  host_rd_i,
  output arc_pkg::arc_word_t     result_bus_o,
  output logic                   result_bus_oe_o,
  // status
  output arc_pkg::arc_status_t   status_o
);
  import arc_pkg::*;

  localparam int WAKE_C = `ARC_WAKE_CYC;
  localparam int DIV_C  = `ARC_CONV_DIV;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [2:0] count_sel(input logic [3:0] m);
    count_sel = 3'({2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]});
  endfunction

  function automatic logic [1:0] lowest_sel(input logic [3:0] m);
    lowest_sel = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) lowest_sel = 2'(i);
    end
  endfunction

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  arc_state_t  state;
  logic [19:0] pw_cnt;
  logic        low_power_request_n_long;
  logic [4:0]  div_cnt;
  logic        tick;
  logic [3:0]  cyc;
  logic [3:0]  remain;
  logic [2:0]  nsel;
  logic [2:0]  written;
  logic [1:0]  ptr;
  logic [1:0]  next_ptr;
  logic        rd_prev;
  logic        trig_prev;
  logic        busy;
  logic        eoc_n;
  logic        first_flag;
  logic        mem_we;
  logic        low_power;
  logic        ready;

  wire logic   rd_rise   = host_rd_i.rd_n && !rd_prev && !host_rd_i.cs_n;
  wire logic   trig_rise = sample_trigger_n_i && !trig_prev;
  wire logic   xfer      = tick && (cyc == `ARC_XFER_CYC);
  // channels still to convert once the current one is done
  wire logic [3:0] remain_left = remain & ~(4'h1 << core_ch_o);
  wire logic   seq_end   = tick && (cyc == `ARC_CONV_CYCLES) && (remain_left == 4'h0);
  wire logic [1:0] last  = 2'(nsel - 3'h1);
  wire logic [19:0] wake_target = low_power_request_n_long ? 20'(P_POWERUP_CYC) : 20'(WAKE_C);

  assign status_o = '{busy: busy, eoc_n: eoc_n, first_result_flag: first_flag,
                      low_power: low_power, ready: ready};

  // ---------------------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------------------
  // a long standby is charged the full power-up time as its wake time
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state     <= ARC_PWRUP;
      pw_cnt    <= '0;
      low_power_request_n_long <= 1'b0;
    end else begin
      case (state)
        ARC_PWRUP: begin
          pw_cnt <= pw_cnt + 20'h1;
          if (pw_cnt == 20'(P_POWERUP_CYC - 1)) begin
            state  <= ARC_IDLE;
            pw_cnt <= '0;
          end
        end
        ARC_IDLE: begin
          if (!low_power_request_n_i) begin
            state  <= ARC_LOW_POWER_REQUEST_N;
            pw_cnt <= '0;
          end else if (trig_rise && (chan_sel_i != 4'h0)) begin
            state <= ARC_CONV;
          end
        end
        ARC_CONV: begin
          if (seq_end) begin
            state <= ARC_IDLE;
          end
        end
        ARC_LOW_POWER_REQUEST_N: begin
          if (pw_cnt != 20'(P_LONG_LOW_POWER_REQUEST_N_CYC)) begin
            pw_cnt <= pw_cnt + 20'h1;
          end
          if (low_power_request_n_i) begin
            state     <= ARC_WAKE;
            low_power_request_n_long <= (pw_cnt == 20'(P_LONG_LOW_POWER_REQUEST_N_CYC));
            pw_cnt    <= '0;
          end
        end
        ARC_WAKE: begin
          if (!low_power_request_n_i) begin
            state  <= ARC_LOW_POWER_REQUEST_N;
            pw_cnt <= '0;
          end else if (pw_cnt == wake_target - 20'h1) begin
            state  <= ARC_IDLE;
            pw_cnt <= '0;
          end else begin
            pw_cnt <= pw_cnt + 20'h1;
          end
        end
        default: begin
          state <= ARC_PWRUP;
        end
      endcase
    end
  end

  // power flags are taken from the next state, so they are flops yet never lag
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_power <= 1'b0;
      ready     <= 1'b0;
    end else begin
      low_power <= !low_power_request_n_i && ((state == ARC_IDLE) || (state == ARC_LOW_POWER_REQUEST_N)
                                              || (state == ARC_WAKE));
      ready     <= ((state == ARC_PWRUP) && (pw_cnt == 20'(P_POWERUP_CYC - 1)))
                   || ((state == ARC_IDLE) && low_power_request_n_i
                       && !(trig_rise && (chan_sel_i != 4'h0)))
                   || ((state == ARC_CONV) && seq_end)
                   || ((state == ARC_WAKE) && low_power_request_n_i
                       && (pw_cnt == wake_target - 20'h1));
    end
  end

  // ---------------------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else if (state == ARC_CONV) begin
      tick    <= (div_cnt == 5'(DIV_C - 1));
      div_cnt <= (div_cnt == 5'(DIV_C - 1)) ? 5'h0 : div_cnt + 5'h1;
    end else begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cyc       <= `ARC_CYC_FIRST;
      remain    <= '0;
      nsel      <= `ARC_NSEL_RESET;
      written   <= '0;
      core_ch_o <= '0;
      busy      <= 1'b0;
      eoc_n     <= 1'b1;
    end else if ((state == ARC_IDLE) && low_power_request_n_i && trig_rise
                 && (chan_sel_i != 4'h0)) begin
      cyc       <= `ARC_CYC_FIRST;
      remain    <= chan_sel_i;
      nsel      <= count_sel(chan_sel_i);
      written   <= '0;
      core_ch_o <= lowest_sel(chan_sel_i);
      busy      <= 1'b1;
    end else if (tick) begin
      cyc <= (cyc == `ARC_CONV_CYCLES) ? `ARC_CYC_FIRST : cyc + 4'h1;
      if (cyc == `ARC_XFER_CYC) begin
        eoc_n   <= 1'b0;
        written <= written + 3'h1;
      end
      if (cyc == `ARC_CONV_CYCLES) begin
        eoc_n     <= 1'b1;
        remain    <= remain_left;
        core_ch_o <= lowest_sel(remain_left);
        if (remain_left == 4'h0) begin
          busy <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // result store and read pointer
  // ---------------------------------------------------------------------------
  // results are written densely: slot index is the count already converted
  assign mem_we = xfer;

  arc_result_mem u_mem (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (written[1:0]),
    .wr_data_i (core_result_i),
    .rd_addr_i (next_ptr),
    .rd_data_o (result_bus_o)
  );

  // the converter owns the pointer on its transfer ticks; a read edge in the
  // same cycle loses, since the host cannot yet see the new slot anyway
  always_comb begin
    next_ptr = ptr;
    if (tick && (cyc == `ARC_PTR_RESET_CYC) && (written == 3'h0)) begin
      next_ptr = `ARC_PTR_FIRST;
    end else if (xfer && (written != 3'h0)) begin
      next_ptr = written[1:0];
    end else if (rd_rise) begin
      if (ptr == last) begin
        next_ptr = `ARC_PTR_FIRST;
      end else if (!busy || ({1'b0, ptr} + 3'h1 < written)) begin
        next_ptr = ptr + 2'h1;
      end
    end
  end

  // standby neither clears the store nor moves the pointer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr        <= `ARC_PTR_FIRST;
      first_flag <= 1'b1;
    end else begin
      ptr        <= next_ptr;
      first_flag <= (next_ptr == `ARC_PTR_FIRST);
    end
  end

  // output enable works in every power state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_bus_oe_o <= 1'b0;
      rd_prev         <= 1'b1;
      trig_prev       <= 1'b1;
    end else begin
      result_bus_oe_o <= !host_rd_i.cs_n && !host_rd_i.rd_n;
      rd_prev         <= host_rd_i.rd_n;
      trig_prev       <= sample_trigger_n_i;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  eoc_fall_a: assert property ($fell(eoc_n) |-> $past(tick && cyc == `ARC_XFER_CYC))
    else $error("strobe fell outside cycle 13");

  eoc_width_a: assert property ($fell(eoc_n) |-> !eoc_n [*2] ##(DIV_C - 1) eoc_n)
    else $error("strobe low time wrong");

  first_flag_a: assert property (first_flag == (ptr == `ARC_PTR_FIRST))
    else $error("first-result flag does not match pointer");

  bus_drive_a: assert property (result_bus_oe_o == $past(!host_rd_i.cs_n && !host_rd_i.rd_n))
    else $error("bus enable not tied to select and read");

  hold_busy_a: assert property ((rd_rise && busy && !tick && ptr != last
                                 && ({1'b0, ptr} + 3'h1 >= written)) |=> $stable(ptr))
    else $error("pointer advanced onto invalid register");

  adv_idle_a: assert property ((rd_rise && !busy && !tick && ptr != last)
                               |=> ptr == 2'($past(ptr) + 2'h1))
    else $error("pointer did not advance after sequence");

  wrap_last_a: assert property ((rd_rise && !tick && ptr == last) |=> ptr == `ARC_PTR_FIRST)
    else $error("pointer did not wrap after last result");

  xfer_adv_a: assert property ((xfer && written != 3'h0) |=> ptr == 2'($past(written)))
    else $error("pointer missed transfer");

  low_power_request_n_keep_a: assert property ((state == ARC_LOW_POWER_REQUEST_N && !rd_rise) |=> $stable(ptr))
    else $error("standby moved the pointer");

  wake_short_a: assert property (($rose(state == ARC_WAKE) && !low_power_request_n_long && low_power_request_n_i)
                                 |-> ##WAKE_C (state != ARC_WAKE))
    else $error("short wake time wrong");

  ready_track_a: assert property (ready == (state == ARC_IDLE))
    else $error("ready flag does not follow idle state");

  low_power_a: assert property (low_power == (state == ARC_LOW_POWER_REQUEST_N))
    else $error("low-power flag does not follow standby state");

  seq_stop_a: assert property ((state == ARC_CONV && !busy) |-> !tick)
    else $error("conversion ran past the last selected channel");

  seq_done_c: cover property ($fell(busy));
  wrap_c: cover property (rd_rise && ptr == last && !busy);
  low_power_request_n_read_c: cover property (state == ARC_LOW_POWER_REQUEST_N && result_bus_oe_o);
  live_read_c: cover property (busy && rd_rise);

endmodule // arc_readout

// ### rtl/arc_cfg.svh
// constants of the result readout and standby block
// assumes a 125 MHz system clock and a 5 MHz conversion clock derived from it
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH

// -----------------------------------------------------------------------------
// clocking
// -----------------------------------------------------------------------------
`define ARC_CLK_NS          8
`define ARC_CLK_MHZ         125
`define ARC_CONV_CLK_NS     200
`define ARC_CONV_DIV        (`ARC_CONV_CLK_NS / `ARC_CLK_NS)

// -----------------------------------------------------------------------------
// conversion cycle positions, in conversion-clock cycles
// -----------------------------------------------------------------------------
`define ARC_CONV_CYCLES     4'he
`define ARC_PTR_RESET_CYC   4'hc
`define ARC_XFER_CYC        4'hd
`define ARC_CYC_FIRST       4'h1

// -----------------------------------------------------------------------------
// power timing
// -----------------------------------------------------------------------------
`define ARC_WAKE_NS         2000
`define ARC_WAKE_CYC        ((`ARC_WAKE_NS * `ARC_CLK_MHZ + 999) / 1000)
`define ARC_LONG_LOW_POWER_REQUEST_N_US    1000
`define ARC_LONG_LOW_POWER_REQUEST_N_CYC   (`ARC_LONG_LOW_POWER_REQUEST_N_US * `ARC_CLK_MHZ)
`define ARC_POWERUP_US      6000
`define ARC_POWERUP_CYC     (`ARC_POWERUP_US * `ARC_CLK_MHZ)

// -----------------------------------------------------------------------------
// result storage
// -----------------------------------------------------------------------------
`define ARC_DATA_W          12
`define ARC_NUM_REGS        4
`define ARC_PTR_FIRST       2'h0
`define ARC_NSEL_RESET      3'h4

`endif

// ### rtl/arc_pkg.sv
// types shared by the result readout and standby block
// assumes arc_cfg.svh is on the include path
`include "arc_cfg.svh"

package arc_pkg;

  // ---------------------------------------------------------------------------
  // states and carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ARC_PWRUP,
    ARC_IDLE,
    ARC_CONV,
    ARC_LOW_POWER_REQUEST_N,
    ARC_WAKE
  } arc_state_t;

  typedef logic [`ARC_DATA_W-1:0] arc_word_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
  } arc_host_rd_t;

  typedef struct packed {
    logic busy;
    logic eoc_n;
    logic first_result_flag;
    logic low_power;
    logic ready;
  } arc_status_t;

endpackage

// ### rtl/arc_result_mem.sv
// four-word result store with a registered read port
// assumes one writer and one reader in the clk_i domain
`timescale 1ns/1ns
`include "arc_cfg.svh"

module arc_result_mem (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // write side
  input  wire logic              wr_en_i,
  input  wire logic [1:0]        wr_addr_i,
  input  arc_pkg::arc_word_t     wr_data_i,
  // read side
  input  wire logic [1:0]        rd_addr_i,
  output arc_pkg::arc_word_t     rd_data_o
);
  import arc_pkg::*;

  arc_word_t store [`ARC_NUM_REGS];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `ARC_NUM_REGS; i++) begin
        store[i] <= '0;
      end
    end else if (wr_en_i) begin
      store[wr_addr_i] <= wr_data_i;
    end
  end

  // write-through so a result written this cycle is readable next cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else if (wr_en_i && (wr_addr_i == rd_addr_i)) begin
      rd_data_o <= wr_data_i;
    end else begin
      rd_data_o <= store[rd_addr_i];
    end
  end

endmodule // arc_result_mem

// ### test/arc_host_model.sv
// host processor model: read cycles on the parallel result bus
// assumes the bench calls read_word from its own process, away from rising edges
`timescale 1ns/1ns

module arc_host_model (
  // clock
  input  wire logic             clk_i,
  // bus from the block
  input  arc_pkg::arc_word_t    result_bus_i,
  input  wire logic             result_bus_oe_i,
  // strobes to the block
  output arc_pkg::arc_host_rd_t host_rd_o
);
  import arc_pkg::*;

  arc_word_t last_seen = '0;

  initial host_rd_o = 2'b11;

  // -------------------------------------------------------------------------
  // one read: strobes change on falling edges, held until the block has seen them
  // -------------------------------------------------------------------------
  task automatic read_word(output arc_word_t d);
    @(negedge clk_i);
    host_rd_o <= 2'b00;
    repeat (2) @(negedge clk_i);
    // an undriven bus reads back as the inverse of the last word
    d = result_bus_oe_i ? result_bus_i : ~last_seen;
    last_seen = d;
    host_rd_o.rd_n <= 1'b1;
    @(negedge clk_i);
    host_rd_o.cs_n <= 1'b1;
    @(negedge clk_i);
  endtask
endmodule // arc_host_model

// ### test/testbench.sv
// self-checking bench for the result readout and standby block
// assumes arc_readout with shortened power counts and arc_host_model as the host
`timescale 1ns/1ns

module testbench;
  import arc_pkg::*;

  logic          clk_i     = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          trig_n    = 1'b1;
  logic          lp_n      = 1'b1;
  logic [3:0]    sel       = 4'hf;
  logic [5:0]    seq       = 6'h00;
  logic          cs_q      = 1'b1;
  arc_word_t     core_res  = '0;
  logic [1:0]    core_ch;
  arc_host_rd_t  host_rd;
  arc_word_t     bus;
  logic          oe;
  arc_status_t   st;
  int            n_mismatch = 0;
  int            samples_checked = 0;

  initial forever #4 clk_i = ~clk_i;

  // core result stamps the sequence number and the channel converted
  always @(negedge clk_i) core_res <= {4'ha, seq, core_ch};

  arc_readout #(.P_LONG_LOW_POWER_REQUEST_N_CYC(50), .P_POWERUP_CYC(100)) dut (
    .clk_i                 (clk_i),
    .sys_rst_i             (sys_rst_i),
    .sample_trigger_n_i    (trig_n),
    .chan_sel_i            (sel),
    .low_power_request_n_i (lp_n),
    .core_result_i         (core_res),
    .core_ch_o             (core_ch),
    .host_rd_i             (host_rd),
    .result_bus_o          (bus),
    .result_bus_oe_o       (oe),
    .status_o              (st)
  );

  arc_host_model host (
    .clk_i           (clk_i),
    .result_bus_i    (bus),
    .result_bus_oe_i (oe),
    .host_rd_o       (host_rd)
  );

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int k);
    return k == 0 ? st.busy : k == 1 ? st.eoc_n : k == 2 ? st.ready : st.low_power;
  endfunction

  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  function automatic logic [1:0] slot_ch(input logic [3:0] m, input int i);
    int c = 0;
    for (int b = 0; b < 4; b++) begin
      if (m[b]) begin
        if (c == i) return b[1:0];
        c++;
      end
    end
    return 2'h0;
  endfunction

  task automatic start(input logic [3:0] m);
    sel    <= m;
    seq    <= seq + 6'h01;
    trig_n <= 1'b0;
    @(negedge clk_i);
    trig_n <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk(st.busy, 1'b1);
  endtask

  // bus stays released once the host has left it unselected for two samples in a row
  always @(negedge clk_i) begin
    if (!sys_rst_i && host_rd.cs_n && cs_q) chk(oe, 1'b0);
    cs_q <= host_rd.cs_n;
  end

  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic t_after(input logic [3:0] m, input int k);
    int n;
    arc_word_t d;
    start(m);
    wait_for(0, 1'b0, 2000, n);
    chk(n > k * 350 - 40 && n < k * 350 + 40, 1'b1);
    chk(st.first_result_flag, k == 1);
    host.read_word(d);
    chk(d, {4'ha, seq, slot_ch(m, k - 1)});
    for (int i = 0; i < k; i++) begin
      chk(st.first_result_flag, i == 0);
      host.read_word(d);
      chk(d, {4'ha, seq, slot_ch(m, i)});
    end
    chk(st.first_result_flag, 1'b1);
  endtask

  task automatic t_during;
    int n;
    arc_word_t d;
    start(4'hf);
    wait_for(1, 1'b0, 400, n);
    chk(st.first_result_flag, 1'b1);
    wait_for(1, 1'b1, 40, n);
    chk(n, 25);
    host.read_word(d);
    chk(d, {4'ha, seq, 2'h0});
    host.read_word(d);
    chk(d, {4'ha, seq, 2'h0});
    wait_for(1, 1'b0, 400, n);
    chk(st.first_result_flag, 1'b0);
    host.read_word(d);
    chk(d, {4'ha, seq, 2'h1});
    wait_for(0, 1'b0, 1200, n);
    host.read_word(d);
    chk(d, {4'ha, seq, 2'h3});
    chk(st.first_result_flag, 1'b1);
  endtask

  task automatic t_standby;
    int n;
    arc_word_t d;
    start(4'h3);
    wait_for(0, 1'b0, 1000, n);
    lp_n <= 1'b0;
    wait_for(3, 1'b1, 4, n);
    chk(st.low_power, 1'b1);
    chk(st.ready, 1'b0);
    host.read_word(d);
    chk(d, {4'ha, seq, 2'h1});
    lp_n <= 1'b1;
    wait_for(2, 1'b1, 400, n);
    chk(n > 240 && n < 262, 1'b1);
    chk(st.low_power, 1'b0);
    lp_n <= 1'b0;
    repeat (80) @(negedge clk_i);
    lp_n <= 1'b1;
    wait_for(2, 1'b1, 400, n);
    chk(n > 90 && n < 112, 1'b1);
    host.read_word(d);
    chk(d, {4'ha, seq, 2'h0});
  endtask

  // -------------------------------------------------------------------------
  // run control
  // -------------------------------------------------------------------------
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #160000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    int n;
    repeat (5) @(negedge clk_i);
    chk(st.first_result_flag, 1'b1);
    chk(st.eoc_n, 1'b1);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk(st.ready, 1'b0);
    wait_for(2, 1'b1, 200, n);
    chk(n > 95 && n < 106, 1'b1);
    t_after(4'hf, 4);
    t_after(4'h5, 2);
    t_after(4'h8, 1);
    t_during();
    t_standby();
    wrap_up();
  end
endmodule // testbench
